/* File: src/eup_pkg.sv */
// shared constants for the e-paper update command set
package eup_pkg;
   localparam int unsigned CLK_HZ          = 125_000_000;
   // command codes
   localparam logic [7:0] CMD_TEMP_READ    = 8'h1b;
   localparam logic [7:0] CMD_SENSOR_WR    = 8'h1c;
   localparam logic [7:0] CMD_ACTIVATE     = 8'h20;
   localparam logic [7:0] CMD_UPD_CTRL     = 8'h21;
   localparam logic [7:0] CMD_UPD_SEQ      = 8'h22;
   localparam logic [7:0] CMD_MONO_WR      = 8'h24;
   localparam logic [7:0] CMD_RED_WR       = 8'h26;
   localparam logic [7:0] CMD_RAM_RD       = 8'h27;
   localparam logic [7:0] CMD_VCOM_SENSE   = 8'h28;
   localparam logic [7:0] CMD_SENSE_DUR    = 8'h29;
   localparam logic [7:0] CMD_VCOM_PROG    = 8'h2a;
   localparam logic [7:0] CMD_VCOM_WR      = 8'h2c;
   localparam logic [7:0] CMD_OPT_READ     = 8'h2d;
   // reset values
   localparam logic [7:0] RST_SENSOR_PAR   = 8'h00;
   localparam logic [7:0] RST_UPD_CTRL     = 8'h00;
   localparam logic [7:0] RST_UPD_SEQ      = 8'hff;
   localparam logic [3:0] RST_SENSE_DUR    = 4'h9;
   localparam logic [7:0] RST_VCOM         = 8'h00;
   localparam logic [11:0] RST_TEMP        = 12'h7f0;
   // ram option codes per nibble
   localparam logic [3:0] RAM_OPT_NORMAL   = 4'h0;
   localparam logic [3:0] RAM_OPT_ZERO     = 4'h4;
   localparam logic [3:0] RAM_OPT_INVERT   = 4'h8;
   // sensor byte-count codes
   localparam logic [1:0] SNS_ADDR_PTR     = 2'b00;
   localparam logic [1:0] SNS_ADDR_ONLY    = 2'b11;
   // sequence option bits
   localparam int unsigned SEQ_CLK_EN      = 7;
   localparam int unsigned SEQ_ANA_EN      = 6;
   localparam int unsigned SEQ_TEMP_LD     = 5;
   localparam int unsigned SEQ_LUT_LD      = 4;
   localparam int unsigned SEQ_MODE2       = 3;
   localparam int unsigned SEQ_DISPLAY     = 2;
   localparam int unsigned SEQ_ANA_DIS     = 1;
   localparam int unsigned SEQ_CLK_DIS     = 0;
   // timing, counts and limits
   localparam int unsigned SENSE_UNIT_S    = 1;
   localparam int unsigned SENSE_UNIT_CYC  = SENSE_UNIT_S * CLK_HZ;
   localparam int unsigned STEP_CYC        = 16;
   localparam int unsigned SNS_BYTE_CYC    = 8;
   localparam int unsigned OPT_BYTES       = 11;
   localparam int unsigned VCOM_MIN        = 8'h08;
   localparam int unsigned VCOM_MAX        = 8'h78;
endpackage : eup_pkg

/* File: src/eup_if.sv */
// link between host and panel controller: serial-byte level
`timescale 1ns/100ps
interface eup_if;
   logic       dc_data;     // 0 command, 1 parameter/data
   logic       wr_stb;      // host byte valid, one cycle
   logic [7:0] wr_byte;
   logic       rd_stb;      // host read request, one cycle
   logic       rd_valid;    // device answer, one cycle
   logic [7:0] rd_byte;
   logic       busy;
   modport dev  (input dc_data, wr_stb, wr_byte, rd_stb, output rd_valid, rd_byte, busy);
   modport host (output dc_data, wr_stb, wr_byte, rd_stb, input rd_valid, rd_byte, busy);
endinterface : eup_if

/* File: src/eup_device.sv */
// panel controller end: command decoder, option registers, update engine
`timescale 1ns/100ps
module eup_device #(
   parameter int unsigned DEPTH     = 4096,
   parameter int unsigned SENSE_CYC = eup_pkg::SENSE_UNIT_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   eup_if.dev               link,
   input  wire logic [11:0] temp_in,
   input  wire logic        read_red_sel,
   input  wire logic [7:0]  opt_bytes [0:9],
   output logic            clk_on,
   output logic            ana_on,
   output logic            sns_active,
   output logic [7:0]      sns_byte,
   output logic            disp_active,
   output logic [7:0]      upd_ctrl,
   output logic            src_mode,
   output logic [7:0]      vcom_otp,
   output logic [7:0]      vcom_sensed
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [7:0] SNS_ADDR = 8'h90; // sensor bus address, value arbitrary
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SNS   = 3'b001,
      ST_SEQ   = 3'b010,
      ST_SENSE = 3'b011,
      ST_PROG  = 3'b100
   } eup_st_e;

   logic [7:0]  mono_plane_memory [0:DEPTH-1];
   logic [7:0]  red_plane [0:DEPTH-1];

   eup_st_e st, next_st;
   logic [7:0]  cmd, next_cmd;
   logic [3:0]  pidx, next_pidx;
   logic [7:0]  sns_a, next_sns_a, sns_b, next_sns_b, sns_c, next_sns_c;
   logic [7:0]  upd_b, next_upd_b, seq, next_seq, vcom, next_vcom;
   logic [3:0]  sdur, next_sdur;
   logic [11:0] temp, next_temp;
   logic [AW-1:0] addr, next_addr;
   logic [31:0] cnt, next_cnt;
   logic [2:0]  step, next_step;
   logic        next_clk_on, next_ana_on, next_sns_active, next_disp_active;
   logic [7:0]  next_sns_byte, next_upd_ctrl, next_vcom_otp, next_vcom_sensed;
   logic        next_busy, next_rd_valid, next_rd_first, rd_first;
   logic [7:0]  next_rd_byte;
   logic        wr_mono, wr_red;
   logic [3:0]  sense_sec, next_sense_sec;

   // answer byte for the option read command
   function automatic logic [7:0] opt_byte(input logic [3:0] i, input logic [7:0] v,
                                           input logic [7:0] o [0:9]);
      if (i == 4'd0) return o[0];
      if (i == 4'd1) return v;
      return o[i-4'd1];
   endfunction : opt_byte

   // number of sensor bytes beyond the address
   function automatic logic [1:0] sns_count(input logic [1:0] code);
      case (code)
         eup_pkg::SNS_ADDR_PTR:  return 2'd1;
         eup_pkg::SNS_ADDR_ONLY: return 2'd0;
         2'b01:                  return 2'd2;
         default:                return 2'd3;
      endcase
   endfunction : sns_count

   // index of the last parameter a sensor transfer waits for
   function automatic logic [3:0] sns_last(input logic [1:0] code);
      return (sns_count(code) > 2'd1) ? 4'(sns_count(code) - 2'd1) : 4'd0;
   endfunction : sns_last

   // command decoding, parameter capture and sequencing
   always_comb begin
      next_st = st; next_cmd = cmd; next_pidx = pidx;
      next_sns_a = sns_a; next_sns_b = sns_b; next_sns_c = sns_c;
      next_upd_b = upd_b; next_seq = seq; next_vcom = vcom; next_sdur = sdur;
      next_temp = temp; next_addr = addr; next_cnt = cnt; next_step = step;
      next_clk_on = clk_on; next_ana_on = ana_on; next_sns_active = 1'b0;
      next_sns_byte = sns_byte; next_disp_active = 1'b0;
      next_upd_ctrl = upd_ctrl; next_vcom_otp = vcom_otp; next_vcom_sensed = vcom_sensed;
      next_rd_valid = 1'b0; next_rd_byte = link.rd_byte; next_rd_first = rd_first;
      wr_mono = 1'b0; wr_red = 1'b0;
      if (link.wr_stb && !link.dc_data) begin
         next_cmd = link.wr_byte;
         next_pidx = 4'd0;
         next_addr = '0;
         next_rd_first = 1'b1;
         if (st == ST_IDLE) begin
            case (link.wr_byte)
               eup_pkg::CMD_ACTIVATE: begin
                  next_st = ST_SEQ; next_step = 3'd0; next_cnt = '0;
               end
               eup_pkg::CMD_VCOM_SENSE: if (clk_on && ana_on) begin
                  next_st = ST_SENSE; next_cnt = '0; next_step = 3'd0;
               end
               eup_pkg::CMD_VCOM_PROG: if (clk_on) begin
                  next_st = ST_PROG; next_cnt = '0;
               end
               default: ;
            endcase
         end
      end else if (link.wr_stb && link.dc_data) begin
         next_pidx = pidx + 4'd1;
         case (cmd)
            eup_pkg::CMD_SENSOR_WR: begin
               if (pidx == 4'd0) next_sns_a = link.wr_byte;
               if (pidx == 4'd1) next_sns_b = link.wr_byte;
               if (pidx == 4'd2) next_sns_c = link.wr_byte;
               // transfer starts once its last parameter is in, never without clock
               if (st == ST_IDLE && clk_on && pidx == sns_last(next_sns_a[7:6])) begin
                  next_st = ST_SNS; next_step = 3'd0; next_cnt = '0;
               end
            end
            eup_pkg::CMD_UPD_CTRL: begin
               if (pidx == 4'd0) next_upd_ctrl = link.wr_byte;
               if (pidx == 4'd1) next_upd_b = link.wr_byte;
            end
            eup_pkg::CMD_UPD_SEQ:   if (pidx == 4'd0) next_seq = link.wr_byte;
            eup_pkg::CMD_SENSE_DUR: if (pidx == 4'd0) next_sdur = link.wr_byte[3:0];
            eup_pkg::CMD_VCOM_WR:   if (pidx == 4'd0) next_vcom = link.wr_byte;
            eup_pkg::CMD_MONO_WR: begin
               wr_mono = 1'b1; next_addr = addr + AW'(1);
            end
            eup_pkg::CMD_RED_WR: begin
               wr_red = 1'b1; next_addr = addr + AW'(1);
            end
            default: ;
         endcase
      end else if (link.rd_stb) begin
         next_rd_valid = 1'b1;
         next_pidx = pidx + 4'd1;
         case (cmd)
            eup_pkg::CMD_TEMP_READ:
               next_rd_byte = (pidx == 4'd0) ? temp[11:4] : {temp[3:0], 4'h0};
            eup_pkg::CMD_RAM_RD: begin
               next_rd_first = 1'b0;
               next_rd_byte = rd_first ? 8'h00 :
                              (read_red_sel ? red_plane[addr] : mono_plane_memory[addr]);
               if (!rd_first) next_addr = addr + AW'(1);
            end
            eup_pkg::CMD_OPT_READ:
               next_rd_byte = (pidx < 4'(eup_pkg::OPT_BYTES)) ? opt_byte(pidx, vcom, opt_bytes) : 8'h00;
            default: next_rd_byte = 8'h00;
         endcase
      end
      // background operations
      case (st)
         ST_SNS: begin
            next_sns_active = 1'b1;
            next_cnt = cnt + 32'd1;
            if (cnt == 32'(eup_pkg::SNS_BYTE_CYC - 1)) begin
               next_cnt = '0;
               next_sns_byte = (step == 3'd0) ? SNS_ADDR : (step == 3'd1) ? {2'b00, sns_a[5:0]} :
                               (step == 3'd2) ? sns_b : sns_c;
               if (step == 3'(sns_count(sns_a[7:6]))) next_st = ST_IDLE;
               else next_step = step + 3'd1;
            end
         end
         ST_SEQ: begin
            next_cnt = cnt + 32'd1;
            if (step == 3'd3 && seq[eup_pkg::SEQ_DISPLAY]) next_disp_active = 1'b1;
            if (cnt == 32'(eup_pkg::STEP_CYC - 1)) begin
               next_cnt = '0;
               next_step = step + 3'd1;
               case (step)
                  3'd0: if (seq[eup_pkg::SEQ_CLK_EN]) next_clk_on = 1'b1;
                  3'd1: if (seq[eup_pkg::SEQ_ANA_EN]) next_ana_on = 1'b1;
                  3'd2: if (seq[eup_pkg::SEQ_TEMP_LD]) next_temp = temp_in;
                  3'd3: ; // lut load or display pass
                  3'd4: if (seq[eup_pkg::SEQ_ANA_DIS] || seq[eup_pkg::SEQ_DISPLAY]) next_ana_on = 1'b0;
                  default: begin
                     if (seq[eup_pkg::SEQ_CLK_DIS] || seq[eup_pkg::SEQ_LUT_LD] ||
                         seq[eup_pkg::SEQ_DISPLAY]) next_clk_on = 1'b0;
                     next_st = ST_IDLE;
                  end
               endcase
            end
         end
         ST_SENSE: begin
            next_cnt = cnt + 32'd1;
            if (cnt == 32'(SENSE_CYC - 1)) begin
               next_cnt = '0;
               if (sense_sec == sdur) begin
                  next_vcom_sensed = vcom;
                  next_st = ST_IDLE;
               end
            end
         end
         ST_PROG: begin
            next_cnt = cnt + 32'd1;
            if (cnt == 32'(eup_pkg::STEP_CYC - 1)) begin
               next_vcom_otp = vcom;
               next_st = ST_IDLE;
            end
         end
         default: ;
      endcase
      next_busy = (next_st != ST_IDLE);
   end

   // seconds counter of the sense hold
   always_comb begin
      next_sense_sec = sense_sec;
      if (st != ST_SENSE) next_sense_sec = 4'd0;
      else if (cnt == 32'(SENSE_CYC - 1)) next_sense_sec = sense_sec + 4'd1;
   end

   // state registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_IDLE; cmd <= 8'h00; pidx <= 4'd0;
         sns_a <= eup_pkg::RST_SENSOR_PAR; sns_b <= eup_pkg::RST_SENSOR_PAR;
         sns_c <= eup_pkg::RST_SENSOR_PAR; upd_b <= eup_pkg::RST_UPD_CTRL;
         seq <= eup_pkg::RST_UPD_SEQ; vcom <= eup_pkg::RST_VCOM; sdur <= eup_pkg::RST_SENSE_DUR;
         temp <= eup_pkg::RST_TEMP; addr <= '0; cnt <= '0; step <= '0; sense_sec <= 4'd0;
         clk_on <= 1'b0; ana_on <= 1'b0; sns_active <= 1'b0; sns_byte <= 8'h00;
         disp_active <= 1'b0; upd_ctrl <= eup_pkg::RST_UPD_CTRL; src_mode <= 1'b0;
         vcom_otp <= 8'h00; vcom_sensed <= 8'h00; rd_first <= 1'b1;
         link.busy <= 1'b0; link.rd_valid <= 1'b0; link.rd_byte <= 8'h00;
      end else if (clk_en) begin
         st <= next_st; cmd <= next_cmd; pidx <= next_pidx;
         sns_a <= next_sns_a; sns_b <= next_sns_b; sns_c <= next_sns_c; upd_b <= next_upd_b;
         seq <= next_seq; vcom <= next_vcom; sdur <= next_sdur; temp <= next_temp;
         addr <= next_addr; cnt <= next_cnt; step <= next_step; sense_sec <= next_sense_sec;
         clk_on <= next_clk_on; ana_on <= next_ana_on; sns_active <= next_sns_active;
         sns_byte <= next_sns_byte; disp_active <= next_disp_active; upd_ctrl <= next_upd_ctrl;
         src_mode <= next_upd_b[7]; vcom_otp <= next_vcom_otp; vcom_sensed <= next_vcom_sensed;
         rd_first <= next_rd_first;
         link.busy <= next_busy; link.rd_valid <= next_rd_valid; link.rd_byte <= next_rd_byte;
      end
   end

   // plane memories, no reset
   always_ff @(posedge clock) begin
      if (clk_en && wr_mono) mono_plane_memory[addr] <= link.wr_byte;
      if (clk_en && wr_red) red_plane[addr] <= link.wr_byte;
   end
endmodule : eup_device

/* File: src/eup_host.sv */
// host end: turns user requests into command and data bytes
`timescale 1ns/100ps
module eup_host (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   eup_if.host             link,
   input  wire logic       req_valid,
   input  wire logic       req_is_data,
   input  wire logic       req_read,
   input  wire logic [7:0] req_byte,
   output logic            req_ready,
   output logic            resp_valid,
   output logic [7:0]      resp_byte,
   output logic            dev_busy
);
   logic next_ready, next_resp_valid, next_busy;
   logic [7:0] next_resp_byte;
   logic next_wr, next_rd, next_dc;
   logic [7:0] next_wbyte;

   // one byte per request; new commands held off while busy
   always_comb begin
      next_wr = 1'b0; next_rd = 1'b0; next_dc = link.dc_data; next_wbyte = link.wr_byte;
      next_ready = !link.busy && !link.wr_stb && !link.rd_stb; // wait until busy can show
      next_resp_valid = link.rd_valid; next_resp_byte = link.rd_valid ? link.rd_byte : resp_byte;
      next_busy = link.busy;
      if (req_valid && req_ready) begin
         if (req_read) next_rd = 1'b1;
         else begin
            next_wr = 1'b1; next_dc = req_is_data; next_wbyte = req_byte;
         end
         next_ready = 1'b0;
      end
   end

   // registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         link.wr_stb <= 1'b0; link.rd_stb <= 1'b0; link.dc_data <= 1'b0; link.wr_byte <= 8'h00;
         req_ready <= 1'b0; resp_valid <= 1'b0; resp_byte <= 8'h00; dev_busy <= 1'b0;
      end else if (clk_en) begin
         link.wr_stb <= next_wr; link.rd_stb <= next_rd; link.dc_data <= next_dc;
         link.wr_byte <= next_wbyte; req_ready <= next_ready; resp_valid <= next_resp_valid;
         resp_byte <= next_resp_byte; dev_busy <= next_busy;
      end
   end
endmodule : eup_host

/* File: bench/eup_checker_sva.sv */
// concurrent checks on the link between host and panel controller
`timescale 1ns/100ps
module eup_checker (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       dc_data,
   input wire logic       wr_stb,
   input wire logic [7:0] wr_byte,
   input wire logic       rd_stb,
   input wire logic       rd_valid,
   input wire logic [7:0] rd_byte,
   input wire logic       busy
);
   logic [7:0] last_cmd;
   logic [3:0] rd_idx;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // remembers the last command and counts answers since it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         last_cmd <= 8'h00;
         rd_idx   <= 4'h0;
      end else if (wr_stb && !dc_data) begin
         last_cmd <= wr_byte;
         rd_idx   <= 4'h0;
      end else if (rd_valid && rd_idx != 4'hf) begin
         rd_idx <= rd_idx + 4'h1;
      end
   end

   property p_rd_answer;
      rd_stb |=> rd_valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read request not answered");
   property p_rd_cause;
      rd_valid |-> $past(rd_stb);
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("answer without request");
   property p_dummy;
      rd_valid && last_cmd == 8'h27 && rd_idx == 4'h0 |-> rd_byte == 8'h00;
   endproperty
   a_dummy: assert property (p_dummy) else $error("first plane read not dummy");
   property p_temp_lo;
      rd_valid && last_cmd == 8'h1b && rd_idx == 4'h1 |-> rd_byte[3:0] == 4'h0;
   endproperty
   a_temp_lo: assert property (p_temp_lo) else $error("temperature low nibble not zero");
   property p_act_busy;
      wr_stb && !dc_data && wr_byte == 8'h20 && !busy |=> busy;
   endproperty
   a_act_busy: assert property (p_act_busy) else $error("activation without busy");
   property p_busy_cause;
      $rose(busy) |-> $past(wr_stb);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy rose without a byte");
   property p_busy_min;
      $rose(busy) |-> busy [*4];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy too short");
   property p_busy_bound;
      $rose(busy) |-> ##[1:1000] !busy;
   endproperty
   a_busy_bound: assert property (p_busy_bound) else $error("busy never ends");
endmodule : eup_checker

/* File: bench/test_epaper_update_command_set.sv */
// self-checking bench joining host and panel controller ends
`timescale 1ns/100ps
module test_epaper_update_command_set;
   logic        clock, rst_n, req_valid, req_is_data, req_read, req_ready, resp_valid, dev_busy, read_red_sel;
   logic        clk_on, ana_on, sns_active, disp_active, src_mode, clk_c, ana_c, disp_seen, sns_seen;
   logic [7:0]  req_byte, resp_byte, upd_ctrl, vcom_otp, rb, v, sns_byte, vcom_sensed;
   logic [1:0]  sns_code [3] = '{2'b00, 2'b11, 2'b10};
   logic [7:0]  mono [4];
   logic [7:0]  red [4];
   logic [7:0]  opt_bytes [0:9];
   logic [11:0] temp_in;
   logic [3:0]  nib [3] = '{4'h0, 4'h4, 4'h8};
   logic [7:0]  codes [12] = '{8'h80, 8'h01, 8'hc0, 8'h03, 8'h91, 8'h99, 8'hb1, 8'hb9, 8'hc7, 8'hcf, 8'hf7, 8'hff};
   int          mismatches, samples_checked, busy_cyc, lens [3];

   eup_if link ();
   eup_device #(.SENSE_CYC(20)) eup_device_i (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .link(link),
      .temp_in(temp_in), .read_red_sel(read_red_sel), .opt_bytes(opt_bytes), .clk_on(clk_on), .ana_on(ana_on),
      .sns_active(sns_active), .sns_byte(sns_byte), .disp_active(disp_active), .upd_ctrl(upd_ctrl),
      .src_mode(src_mode), .vcom_otp(vcom_otp), .vcom_sensed(vcom_sensed));
   eup_host eup_host_i (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .link(link), .req_valid(req_valid),
      .req_is_data(req_is_data), .req_read(req_read), .req_byte(req_byte), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_byte(resp_byte), .dev_busy(dev_busy));
   eup_checker eup_checker_i (.clock(clock), .rst_n(rst_n), .dc_data(link.dc_data), .wr_stb(link.wr_stb),
      .wr_byte(link.wr_byte), .rd_stb(link.rd_stb), .rd_valid(link.rd_valid), .rd_byte(link.rd_byte),
      .busy(link.busy));

   // 125 MHz clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // tallies busy cycles and activity seen during a scenario
   always @(posedge clock) begin
      if (link.busy === 1'b1) busy_cyc = busy_cyc + 1;
      if (disp_active === 1'b1) disp_seen = 1'b1;
      if (sns_active === 1'b1) sns_seen = 1'b1;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one host request, held until taken, then a gap cycle
   task automatic put(input logic d, input logic [7:0] b, input logic r);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_is_data = d;
      req_read = r;
      req_byte = b;
      while (req_ready !== 1'b1 && n < 200) begin
         @(negedge clock);
         n++;
      end
      if (n >= 200) mismatches++; // request never taken
      @(negedge clock);
      req_valid = 1'b0;
      @(negedge clock);
   endtask : put

   task automatic cmd(input logic [7:0] b);
      put(1'b0, b, 1'b0);
   endtask : cmd

   task automatic dat(input logic [7:0] b);
      put(1'b1, b, 1'b0);
   endtask : dat

   task automatic get(output logic [7:0] b);
      int n;
      n = 0;
      put(1'b1, 8'h00, 1'b1);
      while (resp_valid !== 1'b1 && n < 100) begin
         @(negedge clock);
         n++;
      end
      if (n >= 100) mismatches++; // answer never came
      b = resp_byte;
      @(negedge clock);
   endtask : get

   // leaves a running operation alone until busy drops
   task automatic idle();
      int n;
      n = 0;
      repeat (4) @(negedge clock);
      while (link.busy !== 1'b0 && n < 3000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 3000) mismatches++; // busy never dropped
   endtask : idle

   // selects a sequence, activates it and checks the resulting state
   task automatic seq(input logic [7:0] c);
      cmd(8'h22);
      dat(c);
      disp_seen = 1'b0;
      cmd(8'h20);
      idle();
      clk_c = c[0] ? 1'b0 : (c[7] ? 1'b1 : clk_c);
      ana_c = c[1] ? 1'b0 : (c[6] ? 1'b1 : ana_c);
      check({6'h0, clk_on, ana_on}, {6'h0, clk_c, ana_c});
      check({7'h0, disp_seen}, {7'h0, c[2]});
   endtask : seq

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // watchdog against a hung handshake
   initial begin
      #400000;
      mismatches++;
      give_verdict();
   end

   // main sequence
   initial begin
      void'($urandom(48828));
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_is_data = 1'b0;
      req_read = 1'b0;
      req_byte = 8'h00;
      read_red_sel = 1'b0;
      clk_c = 1'b0;
      ana_c = 1'b0;
      temp_in = 12'($urandom);
      for (int i = 0; i < 10; i++) opt_bytes[i] = 8'($urandom);
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      repeat (2) @(negedge clock);
      check(upd_ctrl, 8'h00);
      disp_seen = 1'b0;
      cmd(8'h20);
      idle();
      check({7'h0, disp_seen}, 8'h01);
      busy_cyc = 0;
      cmd(8'h1c);
      dat(8'h00);
      dat(8'h00);
      dat(8'h00);
      idle();
      check(busy_cyc[7:0], 8'h00);
      cmd(8'h1b);
      get(rb);
      check(rb, temp_in[11:4]);
      get(rb);
      check(rb, {temp_in[3:0], 4'h0});
      for (int i = 0; i < 9; i++) begin
         v = {nib[i / 3], nib[i % 3]};
         cmd(8'h21);
         dat(v);
         dat({i[0], 7'h00});
         repeat (3) @(negedge clock);
         check(upd_ctrl, v);
         check({7'h0, src_mode}, {7'h0, i[0]});
      end
      for (int i = 0; i < 12; i++) seq(codes[i]);
      seq(8'hc0);
      for (int k = 0; k < 3; k++) begin
         busy_cyc = 0;
         sns_seen = 1'b0;
         v = {sns_code[k], 6'($urandom)};
         rb = 8'($urandom);
         cmd(8'h1c);
         dat(v);
         dat(8'($urandom));
         dat(rb);
         idle();
         lens[k] = busy_cyc;
         check({7'h0, sns_seen}, 8'h01);
         if (k != 1) check(sns_byte, (k == 0) ? {2'b00, v[5:0]} : rb);
      end
      check({7'h0, lens[1] < lens[0]}, 8'h01);
      check({7'h0, lens[0] < lens[2]}, 8'h01);
      v = 8'h08 + 8'($urandom_range(0, 28)) * 8'h04;
      cmd(8'h2c);
      dat(v);
      cmd(8'h29);
      dat(8'h01);
      busy_cyc = 0;
      cmd(8'h28);
      repeat (3) @(negedge clock);
      check({7'h0, dev_busy}, 8'h01);
      idle();
      check({7'h0, busy_cyc >= 40 && busy_cyc <= 56}, 8'h01);
      check(vcom_sensed, v);
      cmd(8'h2a);
      idle();
      check(vcom_otp, v);
      cmd(8'h2d);
      for (int i = 0; i < 11; i++) begin
         get(rb);
         check(rb, (i == 0) ? opt_bytes[0] : (i == 1) ? v : opt_bytes[i - 1]);
      end
      cmd(8'h24);
      for (int i = 0; i < 4; i++) begin
         mono[i] = 8'($urandom);
         dat(mono[i]);
      end
      cmd(8'h26);
      for (int i = 0; i < 4; i++) begin
         red[i] = 8'($urandom);
         dat(red[i]);
      end
      for (int p = 0; p < 2; p++) begin
         read_red_sel = p[0];
         cmd(8'h27);
         get(rb);
         check(rb, 8'h00);
         for (int i = 0; i < 4; i++) begin
            get(rb);
            check(rb, p[0] ? red[i] : mono[i]);
         end
      end
      give_verdict();
   end
endmodule : test_epaper_update_command_set
